// File: dual_clock_fifo_buffer.sv
// Notes on behaviour
// - Enabled write-clock edge stores the input word
// - Enabled read-clock edge presents the next word
// - Clocks independent; either may stop
// - Standard mode: word shown only after read
// - Fall-through: first word after three transitions
// - Mode pin during master reset picks timing
// - Boundary flags: empty/full or ready indicators
// - Half, almost flags same in both modes
// - Two independent offsets anywhere in depth
// - Default offsets are 127 or 1023
// - Load pin at reset: 127 parallel, 1023 serial
// - Serial enable with load shifts one bit
// - Write enable with load loads offset chunk
// - Read enable with load shows offset chunk
// - Master reset clears pointers, latches settings
// - Partial reset clears pointers, keeps settings
// - Reread moves only read pointer to start
// - Output enable controls data output drive
// - Fall-through units chain without glue
// - Depth 65536 or 131072 nine-bit words
// - Almost-empty low when count below offset
// - Almost-full low when count above limit
// - Both resets clear output register
// - Reread forces empty or not-ready briefly
//
// Chosen here: the placing of the registers and the strobed register port.
`include "dual_clock_fifo_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dual_clock_fifo_buffer
  import dual_clock_fifo_pkg::*;
#(
  parameter int ADDR_W = `FIFO_ADDR_W
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       writeClk,
  input  wire logic       readClk,
  input  wire logic       writeEnN,
  input  wire logic       readEnN,
  input  wire logic       offset_load_n,
  input  wire logic       serial_load_en_n,
  input  wire logic       master_rst_n,
  input  wire logic       partial_rst_n,
  input  wire logic       reread_n,
  input  wire logic       mode_sel_serial_in,
  input  wire logic       outEnN,
  input  wire logic [8:0] data_in,
  output var  logic [8:0] data_out,
  output var  logic       dataOutEn,
  output var  logic       empty_or_out_ready,
  output var  logic       full_or_in_ready,
  output var  logic       half_full_n,
  output var  logic       almost_empty_n,
  output var  logic       almost_full_n
);

  localparam logic [ADDR_W:0]   DEPTH   = {1'b1, {ADDR_W{1'b0}}};
  localparam logic [ADDR_W:0]   HALF    = {2'b01, {(ADDR_W-1){1'b0}}};
  localparam logic [ADDR_W-1:0] DEF_PAR = ADDR_W'(`OFFSET_DEF_PAR);
  localparam logic [ADDR_W-1:0] DEF_SER = ADDR_W'(`OFFSET_DEF_SER);
  localparam logic [1:0]        FALL_LAST = 2'(`FALL_TRANSITIONS - 1);
  localparam int                HI_W    = ADDR_W - `CHUNK_SPLIT;

  // Every pin, clocks included, is sampled by clk; one clock domain keeps pointers coherent
  pinIn_t pinRaw;
  pinIn_t pinMeta;
  pinIn_t pin;
  logic   wclkLast;
  logic   rclkLast;

  assign pinRaw = '{writeClk, readClk, writeEnN, readEnN, offset_load_n, serial_load_en_n,
                    master_rst_n, partial_rst_n, reread_n, mode_sel_serial_in, outEnN, data_in};

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta  <= '{masterRstN: 1'b0, partialRstN: 1'b1, default: '1, dataIn: 9'h000};
      pin      <= '{masterRstN: 1'b0, partialRstN: 1'b1, default: '1, dataIn: 9'h000};
      wclkLast <= 1'b1;
      rclkLast <= 1'b1;
    end
    else
    begin
      pinMeta  <= pinRaw;
      pin      <= pinMeta;
      wclkLast <= pin.writeClk;
      rclkLast <= pin.readClk;
    end
  end

  logic wEdge;
  logic rEdge;
  logic rTrans;
  logic mrsL;
  logic prsL;
  assign wEdge  = pin.writeClk && !wclkLast;
  assign rEdge  = pin.readClk && !rclkLast;
  assign rTrans = pin.readClk != rclkLast;
  assign mrsL   = !pin.masterRstN;
  assign prsL   = !pin.partialRstN;

  // Storage, no reset: contents are undefined until written
  logic [8:0]        mem [0:(1 << ADDR_W) - 1];
  logic [ADDR_W:0]   wptr;
  logic [ADDR_W:0]   rptr;
  logic [ADDR_W-1:0] emptyOff;
  logic [ADDR_W-1:0] fullOff;
  logic [1:0]        loadIdx;
  logic [1:0]        readIdx;
  timingMode_t       mode;
  loadMethod_t       method;
  logic              outValid;
  logic [1:0]        fallCnt;
  logic              rtHold;
  logic [ADDR_W:0]   count;
  logic              isEmpty;
  logic              isFull;

  logic [ADDR_W:0]   next_wptr;
  logic [ADDR_W:0]   next_rptr;
  logic [ADDR_W-1:0] next_emptyOff;
  logic [ADDR_W-1:0] next_fullOff;
  logic [1:0]        next_loadIdx;
  logic [1:0]        next_readIdx;
  timingMode_t       next_mode;
  loadMethod_t       next_method;
  logic              next_outValid;
  logic [1:0]        next_fallCnt;
  logic              next_rtHold;
  logic [8:0]        next_dataOut;
  logic              next_dataOutEn;
  logic              next_emptyOrOr;
  logic              next_fullOrIr;
  logic              next_halfFullN;
  logic              next_almostEmptyN;
  logic              next_almostFullN;
  logic              memWe;

  assign count   = wptr - rptr;
  assign isEmpty = count == '0;
  assign isFull  = count == DEPTH;

  always_comb
  begin
    next_wptr      = wptr;
    next_rptr      = rptr;
    next_emptyOff  = emptyOff;
    next_fullOff   = fullOff;
    next_loadIdx   = loadIdx;
    next_readIdx   = readIdx;
    next_mode      = mode;
    next_method    = method;
    next_outValid  = outValid;
    next_fallCnt   = fallCnt;
    next_rtHold    = rtHold;
    next_dataOut   = data_out;
    next_dataOutEn = !pin.outEnN;
    memWe          = 1'b0;
    if (mrsL)
    begin
      // Straps are followed while held, so the level at release is what stays
      next_mode     = pin.modeSi ? TIMING_FALL_THROUGH : TIMING_STANDARD;
      next_method   = pin.loadN ? LOAD_SERIAL : LOAD_PARALLEL;
      next_emptyOff = pin.loadN ? DEF_SER : DEF_PAR;
      next_fullOff  = pin.loadN ? DEF_SER : DEF_PAR;
      next_wptr     = '0;
      next_rptr     = '0;
      next_loadIdx  = 2'h0;
      next_readIdx  = 2'h0;
      next_outValid = 1'b0;
      next_fallCnt  = 2'h0;
      next_rtHold   = 1'b0;
      next_dataOut  = 9'h000;
    end
    else if (prsL)
    begin
      next_wptr     = '0;
      next_rptr     = '0;
      next_loadIdx  = 2'h0;
      next_readIdx  = 2'h0;
      next_outValid = 1'b0;
      next_fallCnt  = 2'h0;
      next_rtHold   = 1'b0;
      next_dataOut  = 9'h000;
    end
    else
    begin
      if (wEdge)
      begin
        if (!pin.loadN && !pin.serialEnN && method == LOAD_SERIAL)
        begin
          {next_fullOff, next_emptyOff} = {pin.modeSi, fullOff, emptyOff[ADDR_W-1:1]};
        end
        else if (!pin.loadN && !pin.writeEnN && method == LOAD_PARALLEL)
        begin
          next_loadIdx = loadIdx + 2'h1;
          case (loadIdx)
            `CHUNK_EMPTY_LO: next_emptyOff[`CHUNK_SPLIT-1:0] = pin.dataIn;
            `CHUNK_EMPTY_HI: next_emptyOff[ADDR_W-1:`CHUNK_SPLIT] = pin.dataIn[HI_W-1:0];
            `CHUNK_FULL_LO:  next_fullOff[`CHUNK_SPLIT-1:0] = pin.dataIn;
            default:         next_fullOff[ADDR_W-1:`CHUNK_SPLIT] = pin.dataIn[HI_W-1:0];
          endcase
        end
        else if (!pin.writeEnN && pin.loadN && !isFull)
        begin
          memWe     = 1'b1;
          next_wptr = wptr + 1'b1;
        end
      end
      if (rEdge)
      begin
        next_rtHold = 1'b0;
      end
      if (rEdge && !pin.rereadN)
      begin
        next_rptr     = '0;
        next_rtHold   = 1'b1;
        next_outValid = 1'b0;
        next_fallCnt  = 2'h0;
      end
      else if (rEdge && !pin.readEnN && !pin.loadN)
      begin
        next_readIdx = readIdx + 2'h1;
        case (readIdx)
          `CHUNK_EMPTY_LO: next_dataOut = emptyOff[`CHUNK_SPLIT-1:0];
          `CHUNK_EMPTY_HI: next_dataOut = 9'(emptyOff[ADDR_W-1:`CHUNK_SPLIT]);
          `CHUNK_FULL_LO:  next_dataOut = fullOff[`CHUNK_SPLIT-1:0];
          default:         next_dataOut = 9'(fullOff[ADDR_W-1:`CHUNK_SPLIT]);
        endcase
      end
      else if (mode == TIMING_STANDARD)
      begin
        if (rEdge && !pin.readEnN && !isEmpty && !rtHold)
        begin
          next_dataOut = mem[rptr[ADDR_W-1:0]];
          next_rptr    = rptr + 1'b1;
        end
      end
      else if (!outValid)
      begin
        // Fall-through needs no read enable, so chained units pass words on alone
        if (isEmpty || rtHold)
        begin
          next_fallCnt = 2'h0;
        end
        else if (rTrans && fallCnt == FALL_LAST)
        begin
          next_dataOut  = mem[rptr[ADDR_W-1:0]];
          next_rptr     = rptr + 1'b1;
          next_outValid = 1'b1;
          next_fallCnt  = 2'h0;
        end
        else if (rTrans)
        begin
          next_fallCnt = fallCnt + 2'h1;
        end
      end
      else if (rEdge && !pin.readEnN)
      begin
        if (!isEmpty)
        begin
          next_dataOut = mem[rptr[ADDR_W-1:0]];
          next_rptr    = rptr + 1'b1;
        end
        else
        begin
          next_outValid = 1'b0;
        end
      end
    end
    if (mode == TIMING_STANDARD)
    begin
      next_emptyOrOr = !(isEmpty || rtHold);
      next_fullOrIr  = !isFull;
    end
    else
    begin
      next_emptyOrOr = !next_outValid;
      next_fullOrIr  = isFull;
    end
    next_halfFullN    = !(count > HALF);
    next_almostEmptyN = !(count < {1'b0, emptyOff});
    next_almostFullN  = !(count > (DEPTH - {1'b0, fullOff}));
  end

  always_ff @(posedge clk)
  begin
    if (memWe)
    begin
      mem[wptr[ADDR_W-1:0]] <= pin.dataIn;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wptr               <= '0;
      rptr               <= '0;
      emptyOff           <= DEF_PAR;
      fullOff            <= DEF_PAR;
      loadIdx            <= 2'h0;
      readIdx            <= 2'h0;
      mode               <= TIMING_STANDARD;
      method             <= LOAD_PARALLEL;
      outValid           <= 1'b0;
      fallCnt            <= 2'h0;
      rtHold             <= 1'b0;
      data_out           <= 9'h000;
      dataOutEn          <= 1'b0;
      empty_or_out_ready <= 1'b0;
      full_or_in_ready   <= 1'b1;
      half_full_n        <= 1'b1;
      almost_empty_n     <= 1'b0;
      almost_full_n      <= 1'b1;
    end
    else
    begin
      wptr               <= next_wptr;
      rptr               <= next_rptr;
      emptyOff           <= next_emptyOff;
      fullOff            <= next_fullOff;
      loadIdx            <= next_loadIdx;
      readIdx            <= next_readIdx;
      mode               <= next_mode;
      method             <= next_method;
      outValid           <= next_outValid;
      fallCnt            <= next_fallCnt;
      rtHold             <= next_rtHold;
      data_out           <= next_dataOut;
      dataOutEn          <= next_dataOutEn;
      empty_or_out_ready <= next_emptyOrOr;
      full_or_in_ready   <= next_fullOrIr;
      half_full_n        <= next_halfFullN;
      almost_empty_n     <= next_almostEmptyN;
      almost_full_n      <= next_almostFullN;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic quiet;
  assign quiet = !mrsL && !prsL;

  sequence resetHeld;
    mrsL || prsL;
  endsequence

  sequence pointersCleared;
    wptr == '0 && rptr == '0 && data_out == 9'h000;
  endsequence

  sequence fallArmed;
    quiet && mode == TIMING_FALL_THROUGH && !outValid && !isEmpty && !rtHold
      && pin.rereadN && pin.loadN && rTrans && fallCnt == FALL_LAST;
  endsequence

  ptr_reset_a: assert property (resetHeld |=> pointersCleared)
    else $error("reset did not clear pointers and output");
  keep_offsets_a: assert property (quiet ##1 prsL |=> $stable(emptyOff) && $stable(fullOff))
    else $error("partial reset changed offsets");
  write_store_a: assert property (quiet && wEdge && !pin.writeEnN && pin.loadN && !isFull
                                  |=> wptr == $past(wptr) + 1'b1)
    else $error("enabled write not stored");
  full_ignore_a: assert property (quiet && isFull |=> wptr == $past(wptr))
    else $error("write pointer moved while full");
  reread_ptr_a: assert property (quiet && rEdge && !pin.rereadN
                                 |=> rptr == '0 && $stable(wptr) ##1 empty_or_out_ready == (mode != TIMING_STANDARD))
    else $error("reread did not rewind read pointer");
  empty_flag_a: assert property (mode == TIMING_STANDARD && isEmpty |=> !empty_or_out_ready)
    else $error("empty flag not low while empty");
  fall_load_a: assert property (fallArmed |=> outValid ##1 !empty_or_out_ready)
    else $error("first word did not fall through");
  half_full_a: assert property (count > HALF |=> !half_full_n)
    else $error("half-full flag missing");
  almost_empty_a: assert property (count < {1'b0, emptyOff} |=> !almost_empty_n)
    else $error("almost-empty flag missing");
  almost_full_a: assert property (count <= (DEPTH - {1'b0, fullOff}) |=> almost_full_n)
    else $error("almost-full flag set too early");
  out_drive_a: assert property (!pin.outEnN ##1 !pin.outEnN |=> dataOutEn)
    else $error("outputs not driven while enabled");

endmodule

`default_nettype wire

// File: dual_clock_fifo_buffer_sva_note_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: dual_clock_fifo_buffer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_buffer_tb_top;
  logic       clk     = 1'b0;
  logic       rstB    = 1'b0;
  logic       loadN;
  logic       senN;
  logic       mrstN   = 1'b0;
  logic       prstN   = 1'b1;
  logic       rereadN;
  logic       modeSi;
  logic       outEnN;
  wire logic       wClk;
  wire logic       rClk;
  wire logic       wEnN;
  wire logic       rEnN;
  wire logic [8:0] dIn;
  logic [8:0] dOut;
  logic       dOutEn;
  logic       emptyRdy;
  logic       fullRdy;
  logic       halfN;
  logic       aEmptyN;
  logic       aFullN;
  logic [8:0] flags;
  int         failCount  = 0;
  int         checksDone = 0;

  assign flags = {4'h0, emptyRdy, fullRdy, halfN, aEmptyN, aFullN};

  always #25 clk = ~clk;

  fifo_far_side u_far (.clk(clk), .writeClk(wClk), .readClk(rClk), .writeEnN(wEnN), .readEnN(rEnN),
    .dataIn(dIn));

  // Small depth keeps a full fill and drain short
  dual_clock_fifo_buffer #(.ADDR_W(10)) u_dut (.clk(clk), .rst_b(rstB), .writeClk(wClk), .readClk(rClk),
    .writeEnN(wEnN), .readEnN(rEnN), .offset_load_n(loadN), .serial_load_en_n(senN),
    .master_rst_n(mrstN), .partial_rst_n(prstN), .reread_n(rereadN), .mode_sel_serial_in(modeSi),
    .outEnN(outEnN), .data_in(dIn), .data_out(dOut), .dataOutEn(dOutEn), .empty_or_out_ready(emptyRdy),
    .full_or_in_ready(fullRdy), .half_full_n(halfN), .almost_empty_n(aEmptyN), .almost_full_n(aFullN));

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Standard-mode flag word for c stored words, offsets n and m, depth 1024
  function automatic logic [8:0] flagsFor(input int c, input int n, input int m);
    return {4'h0, c != 0, c != 1024, c <= 512, c >= n, c <= 1024 - m};
  endfunction

  task automatic finalReport;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic masterReset(input logic fall_through_mode, input logic serial);
    // Straps and idle levels are driven here, so every scenario starts from known pins
    @(posedge clk);
    mrstN   <= 1'b0;
    modeSi  <= fall_through_mode;
    loadN   <= serial;
    senN    <= 1'b1;
    rereadN <= 1'b1;
    outEnN  <= 1'b1;
    repeat (6) @(posedge clk);
    mrstN  <= 1'b1;
    repeat (2) @(posedge clk);
    loadN  <= 1'b1;
    modeSi <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic partialReset;
    @(posedge clk);
    prstN <= 1'b0;
    repeat (6) @(posedge clk);
    prstN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic readOffsets(input logic [35:0] exp);
    @(posedge clk);
    loadN <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      u_far.rd(1'b1);
      chk("offset chunk", exp[9*i +: 9], dOut);
    end
    loadN <= 1'b1;
  endtask

  task automatic testReset;
    masterReset(1'b0, 1'b0);
    chk("reset flags", flagsFor(0, 127, 127), flags);
    chk("reset data", 9'h000, dOut);
    outEnN <= 1'b0;
    repeat (5) @(posedge clk);
    chk("drive on", 9'h001, {8'h00, dOutEn});
    outEnN <= 1'b1;
    repeat (5) @(posedge clk);
    chk("drive off", 9'h000, {8'h00, dOutEn});
    $display("test reset done");
  endtask

  task automatic testStandard;
    logic [8:0] w [3];
    w = '{9'h155, 9'h0aa, 9'h1c3};
    for (int i = 0; i < 3; i++)
      u_far.wr(1'b1, w[i]);
    chk("no early word", 9'h000, dOut);
    chk("flags three", flagsFor(3, 127, 127), flags);
    for (int i = 0; i < 3; i++)
    begin
      u_far.rd(1'b1);
      chk("read word", w[i], dOut);
    end
    chk("flags drained", flagsFor(0, 127, 127), flags);
    u_far.rd(1'b1);
    chk("read while empty", w[2], dOut);
    rereadN <= 1'b0;
    u_far.rd(1'b0);
    rereadN <= 1'b1;
    chk("empty forced", 9'h000, {8'h00, emptyRdy});
    u_far.rd(1'b0);
    u_far.rd(1'b1);
    chk("reread word", w[0], dOut);
    chk("write side kept", flagsFor(2, 127, 127), flags);
    $display("test standard done");
  endtask

  task automatic testFill;
    partialReset();
    chk("partial data", 9'h000, dOut);
    chk("partial flags", flagsFor(0, 127, 127), flags);
    @(posedge clk);
    loadN <= 1'b0;
    u_far.wr(1'b1, 9'h005);
    u_far.wr(1'b1, 9'h000);
    u_far.wr(1'b1, 9'h003);
    u_far.wr(1'b1, 9'h000);
    loadN <= 1'b1;
    readOffsets({9'h000, 9'h003, 9'h000, 9'h005});
    partialReset();
    readOffsets({9'h000, 9'h003, 9'h000, 9'h005});
    for (int c = 1; c <= 1024; c++)
    begin
      u_far.wr(1'b1, c[8:0]);
      chk("fill flags", flagsFor(c, 5, 3), flags);
    end
    u_far.wr(1'b1, 9'h0aa);
    chk("write while full", flagsFor(1024, 5, 3), flags);
    for (int c = 1; c <= 1024; c++)
    begin
      u_far.rd(1'b1);
      chk("drain word", c[8:0], dOut);
      chk("drain flags", flagsFor(1024 - c, 5, 3), flags);
    end
    $display("test fill done");
  endtask

  task automatic testFallThrough;
    logic [19:0] bits;
    bits = {10'd5, 10'd2};
    masterReset(1'b1, 1'b1);
    chk("ft reset flags", 9'h015, flags);
    readOffsets({9'h001, 9'h1ff, 9'h001, 9'h1ff});
    @(posedge clk);
    loadN <= 1'b0;
    senN  <= 1'b0;
    for (int b = 0; b < 20; b++)
    begin
      modeSi <= bits[b];
      u_far.wr(1'b0, 9'h000);
    end
    senN  <= 1'b1;
    loadN <= 1'b1;
    readOffsets({9'h000, 9'h005, 9'h000, 9'h002});
    u_far.wr(1'b1, 9'h123);
    chk("ft not ready", 9'h001, {8'h00, emptyRdy});
    u_far.rd(1'b0);
    chk("ft two transitions", 9'h001, {8'h00, emptyRdy});
    u_far.rd(1'b0);
    chk("ft first word", 9'h123, dOut);
    chk("ft ready", 9'h000, {8'h00, emptyRdy});
    u_far.wr(1'b1, 9'h0bc);
    u_far.rd(1'b0);
    chk("ft word held", 9'h123, dOut);
    u_far.rd(1'b1);
    chk("ft second word", 9'h0bc, dOut);
    u_far.rd(1'b1);
    chk("ft drained", 9'h001, {8'h00, emptyRdy});
    $display("test fall-through done");
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rstB <= 1'b1;
    testReset();
    testStandard();
    testFill();
    testFallThrough();
    finalReport();
  end

  // Fixed-length frames cannot hang, but a stuck run is still cut short
  initial
  begin
    #4000000;
    failCount++;
    $display("[FAIL] run length expected end seen hang");
    finalReport();
  end
endmodule
`default_nettype wire

// File: dual_clock_fifo_defines.svh
`ifndef DUAL_CLOCK_FIFO_DEFINES_SVH
`define DUAL_CLOCK_FIFO_DEFINES_SVH

// Storage address width, 16 for 65,536 words, 17 for 131,072 words
`define FIFO_ADDR_W        16
`define FIFO_DATA_W        9
// Default threshold offsets chosen at master reset
`define OFFSET_DEF_PAR     127
`define OFFSET_DEF_SER     1023
// Read-clock transitions before the first word falls through
`define FALL_TRANSITIONS   3
// Parallel offset chunk order
`define CHUNK_EMPTY_LO     2'h0
`define CHUNK_EMPTY_HI     2'h1
`define CHUNK_FULL_LO      2'h2
`define CHUNK_FULL_HI      2'h3
// Bit position where the high offset chunk starts
`define CHUNK_SPLIT        9

`endif

// File: dual_clock_fifo_pkg.sv
package dual_clock_fifo_pkg;

  // Pin inputs, sampled together through the synchroniser
  typedef struct packed {
    logic       writeClk;
    logic       readClk;
    logic       writeEnN;
    logic       readEnN;
    logic       loadN;
    logic       serialEnN;
    logic       masterRstN;
    logic       partialRstN;
    logic       rereadN;
    logic       modeSi;
    logic       outEnN;
    logic [8:0] dataIn;
  } pinIn_t;

  typedef enum logic {TIMING_STANDARD, TIMING_FALL_THROUGH} timingMode_t;
  typedef enum logic {LOAD_PARALLEL, LOAD_SERIAL} loadMethod_t;

endpackage

// File: fifo_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_far_side
(
  input  wire logic       clk,
  output var  logic       writeClk,
  output var  logic       readClk,
  output var  logic       writeEnN,
  output var  logic       readEnN,
  output var  logic [8:0] dataIn
);
  initial
  begin
    writeClk = 1'b0;
    readClk  = 1'b0;
  end

  // Enables and word are first driven by the transfer that uses them; the clock edge masks them till then
  // Enable and word held from before the rising edge until the falling edge; clock idles low between frames
  // Calls back to back give a 400 ns clock, four system clocks per half period
  task automatic wr(input logic en, input logic [8:0] d);
    @(posedge clk);
    writeEnN <= ~en;
    dataIn   <= d;
    repeat (1) @(posedge clk);
    writeClk <= 1'b1;
    repeat (4) @(posedge clk);
    writeClk <= 1'b0;
    writeEnN <= 1'b1;
    dataIn   <= ~d;
    repeat (2) @(posedge clk);
  endtask

  // Consumer keeps enable stable across the rising edge
  task automatic rd(input logic en);
    @(posedge clk);
    readEnN <= ~en;
    repeat (1) @(posedge clk);
    readClk <= 1'b1;
    repeat (4) @(posedge clk);
    readClk <= 1'b0;
    readEnN <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire
